// ---- bench/asd_decoder_monitor.sv ----
// Concurrent checks on the ports of the address space decoder.
`timescale 1ns/1ns
module asd_decoder_monitor #(
  parameter bit FLASH_8K = 1'b1
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Register file side.
  input wire logic rf_req_i,
  input wire logic rf_we_i,
  input wire logic [asd_pkg::RF_AW-1:0] rf_addr_i,
  input wire logic [7:0] rf_wdata_i,
  input wire logic rf_rvalid_o,
  input wire logic [asd_pkg::PER_N-1:0] per_sel_o,
  input wire logic per_we_o,
  input wire logic ser_tx_wr_o,
  // Program and data memory side.
  input wire logic pm_req_i,
  input wire logic pm_we_i,
  input wire logic [asd_pkg::PM_AW-1:0] pm_addr_i,
  input wire logic [7:0] pm_rdata_o,
  input wire logic pm_rvalid_o,
  input wire asd_pkg::asd_pmr_t pm_region_o,
  input wire logic info_en_o,
  input wire logic fl_req_o,
  input wire logic fl_we_o,
  input wire logic dm_req_i,
  input wire logic dm_we_i,
  input wire logic [7:0] dm_rdata_o,
  input wire logic dm_rvalid_o
);
  import asd_pkg::*;
  // Last flash byte of the variant under test.
  localparam logic [15:0] LIM = FLASH_8K ? FLASH_LAST_8K : FLASH_LAST_4K;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  // ==========================================================================
  // Register file.
  rd_answer_a: assert property (rf_req_i && !rf_we_i |-> ##2 rf_rvalid_o)
    else $error("read answer missing");
  wr_silent_a: assert property (rf_req_i && rf_we_i |-> ##2 !rf_rvalid_o)
    else $error("write produced a read answer");
  tmr_sel_a: assert property (rf_req_i && rf_addr_i[11:4] == 8'hf0 |=>
    per_sel_o == ($past(rf_addr_i[3]) ? 4'h2 : 4'h1)) else $error("timer select wrong");
  rsv_quiet_a: assert property (rf_req_i &&
    (rf_addr_i inside {[12'h400:12'heff], [12'hf10:12'hf3f]}) |=> per_sel_o == 4'h0 && !per_we_o)
    else $error("reserved address reached a peripheral");
  ser_tx_a: assert property (rf_req_i && rf_we_i && rf_addr_i == SER_DATA |=>
    ser_tx_wr_o && per_we_o && per_sel_o == 4'h4) else $error("transmit write lost");
  info_en_a: assert property (rf_req_i && rf_we_i && rf_addr_i == PGSEL_ADDR |->
    ##2 info_en_o == $past(rf_wdata_i[7], 2)) else $error("info enable not from page bit");

  // ==========================================================================
  // Program and data memory.
  pm_ff_a: assert property (pm_req_i && !pm_we_i && pm_addr_i > LIM &&
    pm_addr_i < INFO_FIRST |=> pm_rvalid_o && pm_rdata_o == PM_UNIMPL_RDATA)
    else $error("unimplemented read not FF");
  fl_we_a: assert property (fl_we_o |-> fl_req_o && pm_we_i && pm_addr_i <= LIM)
    else $error("flash written outside its range");
  overlay_a: assert property (pm_req_i && !pm_we_i && info_en_o &&
    pm_addr_i >= INFO_FIRST |-> !fl_req_o ##1 pm_region_o == PMR_INFO)
    else $error("overlay read went to flash");
  dm_none_a: assert property (dm_req_i && !dm_we_i |=>
    dm_rvalid_o && dm_rdata_o == 8'h00) else $error("data memory answered with data");

  // Main scenarios seen at least once.
  cover property (rf_req_i && rf_addr_i == SER_DATA);
  cover property (pm_rvalid_o && pm_region_o == PMR_INFO);
  cover property (dm_rvalid_o);
endmodule : asd_decoder_monitor

bind asd_decoder asd_decoder_monitor #(.FLASH_8K(FLASH_8K)) mon (
  .ref_clk_i, .resetn_i, .rf_req_i, .rf_we_i, .rf_addr_i, .rf_wdata_i, .rf_rvalid_o,
  .per_sel_o, .per_we_o, .ser_tx_wr_o, .pm_req_i, .pm_we_i, .pm_addr_i, .pm_rdata_o,
  .pm_rvalid_o, .pm_region_o, .info_en_o, .fl_req_o, .fl_we_o, .dm_req_i, .dm_we_i,
  .dm_rdata_o, .dm_rvalid_o);

// ---- bench/asd_far_model.sv ----
// Behavioural flash array and peripheral responder on the decoder's far ports.
`timescale 1ns/1ns
module asd_far_model (
  // Clock.
  input wire logic ref_clk_i,
  // Flash array port.
  input wire logic fl_req_i,
  input wire logic fl_we_i,
  input wire logic [15:0] fl_addr_i,
  input wire logic [7:0] fl_wdata_i,
  output logic [7:0] fl_rdata_o,
  // Peripheral register port.
  input wire logic per_re_i,
  input wire logic [7:0] per_addr_i,
  output logic [7:0] per_rdata_o
);
  logic [7:0] mem_q [0:8191];
  logic [7:0] idle_q;
  // Each byte holds the xor of its address bytes, so every read is checkable.
  initial begin
    for (int i = 0; i < 8192; i++) begin
      mem_q[i] = 8'(i ^ (i >> 8));
    end
    idle_q = 8'h5a;
  end
  // Data comes one cycle after the strobe; otherwise the bus keeps changing,
  // so a stale byte can never pass for a fresh one.
  always @(posedge ref_clk_i) begin
    idle_q <= idle_q + 8'h3d;
    if (fl_req_i && fl_we_i) begin
      mem_q[fl_addr_i[12:0]] <= fl_wdata_i;
    end
    fl_rdata_o <= (fl_req_i && !fl_we_i) ? mem_q[fl_addr_i[12:0]] : ~idle_q;
  end
  // Registers read as C0 plus their low nibble while the read strobe is high.
  assign per_rdata_o = per_re_i ? {4'hc, per_addr_i[3:0]} : idle_q;
endmodule : asd_far_model

// ---- bench/tb_asd_decoder.sv ----
// Self-checking testbench for the address space decoder.
`timescale 1ns/1ns
module tb_asd_decoder;
  import asd_pkg::*;
  // Part identifier handed to the decoder; the value is arbitrary.
  localparam logic [8*PARTID_LEN-1:0] ID = {"ASD-DEMO-0", 80'h0};
  logic ref_clk_i, resetn_i, rf_req_i, rf_we_i, rf_rvalid_o, per_we_o, per_re_o;
  logic ser_tx_wr_o, ser_rx_rd_o, pm_req_i, pm_we_i, pm_rvalid_o, info_en_o;
  logic fl_req_o, fl_we_o, dm_req_i, dm_we_i, dm_rvalid_o, rv, flw;
  logic [11:0] rf_addr_i;
  logic [15:0] pm_addr_i, fl_addr_o;
  logic [7:0] rf_wdata_i, rf_rdata_o, per_addr_o, per_wdata_o, per_rdata_i, rd, pw;
  logic [7:0] pm_wdata_i, pm_rdata_o, fl_wdata_o, fl_rdata_i, dm_rdata_o;
  logic [3:0] per_sel_o, sel;
  logic [3:0] sx;
  asd_pmr_t pm_region_o, rg;
  int error_cnt, compares, cycles;

  // Clock at 25 MHz.
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  asd_decoder #(.PART_ID(ID)) dut (
    .ref_clk_i, .resetn_i, .rf_req_i, .rf_we_i, .rf_addr_i, .rf_wdata_i, .rf_rdata_o,
    .rf_rvalid_o, .per_sel_o, .per_we_o, .per_re_o, .per_addr_o, .per_wdata_o,
    .ser_tx_wr_o, .ser_rx_rd_o, .per_rdata_i, .pm_req_i, .pm_we_i, .pm_addr_i,
    .pm_wdata_i, .pm_rdata_o, .pm_rvalid_o, .pm_region_o, .info_en_o, .fl_req_o,
    .fl_we_o, .fl_addr_o, .fl_wdata_o, .fl_rdata_i, .dm_req_i, .dm_we_i, .dm_rdata_o,
    .dm_rvalid_o);
  asd_far_model far (.ref_clk_i, .fl_req_i(fl_req_o), .fl_we_i(fl_we_o),
    .fl_addr_i(fl_addr_o), .fl_wdata_i(fl_wdata_o), .fl_rdata_o(fl_rdata_i),
    .per_re_i(per_re_o), .per_addr_i(per_addr_o), .per_rdata_o(per_rdata_i));

  // ==========================================================================
  // Shared tasks.
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One register access; strobes are caught in cycle 1, the answer in cycle 2.
  task automatic rf(input logic we, input logic [11:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    rf_req_i = 1'b1;
    rf_we_i = we;
    rf_addr_i = a;
    rf_wdata_i = d;
    @(negedge ref_clk_i);
    rf_req_i = 1'b0;
    sel = per_sel_o;
    sx = {ser_tx_wr_o, ser_rx_rd_o, per_we_o, per_re_o};
    pw = per_wdata_o;
    @(negedge ref_clk_i);
    rd = rf_rdata_o;
    rv = rf_rvalid_o;
  endtask : rf

  // One program memory access; the flash write strobe is combinational.
  task automatic pm(input logic we, input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    pm_req_i = 1'b1;
    pm_we_i = we;
    pm_addr_i = a;
    pm_wdata_i = d;
    #1;
    flw = fl_we_o;
    @(negedge ref_clk_i);
    pm_req_i = 1'b0;
    rd = pm_rdata_o;
    rv = pm_rvalid_o;
    rg = pm_region_o;
  endtask : pm

  // ==========================================================================
  // Scenarios.
  task automatic t_ram();
    rf(1'b1, 12'h000, 8'h3c);
    rf(1'b1, 12'h3ff, 8'hc3);
    rf(1'b1, 12'h400, 8'h99);
    chk("reserved write", sx, 4'h0);
    rf(1'b0, 12'h000, 8'h00);
    chk("ram 000", rd, 8'h3c);
    rf(1'b0, 12'h3ff, 8'h00);
    chk("ram 3ff", rd, 8'hc3);
    rf(1'b0, 12'h400, 8'h00);
    chk("reserved 400", rd, UNDEF_RDATA);
    chk("reserved valid", rv, 1'b1);
    $display("t_ram done");
  endtask : t_ram

  task automatic t_per();
    logic [11:0] a [8] = '{12'hf00, 12'hf07, 12'hf08, 12'hf0f, 12'hf10, 12'hf46, 12'hf3f,
      12'hf47};
    logic [3:0] s [8] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h0, 4'h4, 4'h0, 4'h8};
    for (int i = 0; i < 8; i++) begin
      rf(1'b0, a[i], 8'h00);
      chk("per select", sel, s[i]);
      chk("per read strobe", sx[0], s[i] != 4'h0);
      chk("per data", rd, s[i] == 4'h0 ? UNDEF_RDATA : {4'hc, a[i][3:0]});
    end
    rf(1'b1, SER_DATA, 8'h55);
    chk("tx strobe", sx, 4'b1010);
    chk("tx data", pw, 8'h55);
    rf(1'b0, SER_DATA, 8'h00);
    chk("rx strobe", sx, 4'b0101);
    $display("t_per done");
  endtask : t_per

  task automatic t_pm();
    logic [15:0] a [9] = '{16'h0000, 16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h0037,
      16'h0038, 16'h1fff, 16'h2000};
    asd_pmr_t r [9] = '{PMR_OPT, PMR_RSTV, PMR_WDTV, PMR_TRAPV, PMR_IRQV, PMR_IRQV,
      PMR_CODE, PMR_CODE, PMR_NONE};
    for (int i = 0; i < 9; i++) begin
      pm(1'b0, a[i], 8'h00);
      chk("pm region", rg, r[i]);
      chk("pm valid", rv, 1'b1);
      chk("pm data", rd, a[i] > FLASH_LAST_8K ? PM_UNIMPL_RDATA : a[i][7:0] ^ a[i][15:8]);
    end
    pm(1'b1, 16'h2000, 8'h11);
    chk("write beyond flash", flw, 1'b0);
    pm(1'b1, 16'h0040, 8'h77);
    chk("flash write", flw, 1'b1);
    pm(1'b0, 16'h0040, 8'h00);
    chk("flash readback", rd, 8'h77);
    pm(1'b0, PARTID_FIRST, 8'h00);
    chk("overlay off", rd, PM_UNIMPL_RDATA);
    $display("t_pm done");
  endtask : t_pm

  task automatic t_info();
    rf(1'b1, PGSEL_ADDR, 8'h80);
    chk("page not forwarded", sel, 4'h0);
    chk("info enable", info_en_o, 1'b1);
    rf(1'b0, PGSEL_ADDR, 8'h00);
    chk("page select", rd, 8'h80);
    for (int i = 0; i < PARTID_LEN; i++) begin
      pm(1'b0, PARTID_FIRST + 16'(i), 8'h00);
      chk("part id", rd, ID[8*(PARTID_LEN-1-i) +: 8]);
    end
    pm(1'b0, 16'hfe54, 8'h00);
    chk("id padding", rd, 8'h00);
    pm(1'b0, INFO_FIRST, 8'h00);
    chk("info region", rg, PMR_INFO);
    pm(1'b1, PARTID_FIRST, 8'h00);
    chk("info write", flw, 1'b0);
    pm(1'b0, PARTID_FIRST, 8'h00);
    chk("info kept", rd, ID[8*PARTID_LEN-1 -: 8]);
    rf(1'b1, PGSEL_ADDR, 8'h00);
    chk("info disable", info_en_o, 1'b0);
    $display("t_info done");
  endtask : t_info

  task automatic t_dm();
    for (int w = 0; w < 2; w++) begin
      @(negedge ref_clk_i);
      dm_req_i = 1'b1;
      dm_we_i = w[0];
      @(negedge ref_clk_i);
      dm_req_i = 1'b0;
      chk("dm valid", dm_rvalid_o, !w[0]);
      chk("dm data", dm_rdata_o, 8'h00);
    end
    $display("t_dm done");
  endtask : t_dm

  task automatic give_verdict();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  // A hang is cut short well beyond the 150 or so cycles the run needs.
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // Main sequence.
  initial begin
    {rf_req_i, rf_we_i, pm_req_i, pm_we_i, dm_req_i, dm_we_i} = 6'h00;
    rf_addr_i = 12'h000;
    rf_wdata_i = 8'h00;
    pm_addr_i = 16'h0000;
    pm_wdata_i = 8'h00;
    resetn_i = 1'b0;
    repeat (12) @(negedge ref_clk_i);
    chk("reset region", pm_region_o, PMR_NONE);
    resetn_i = 1'b1;
    t_ram();
    t_per();
    t_pm();
    t_info();
    t_dm();
    give_verdict();
  end
endmodule : tb_asd_decoder

// ---- include/asd_mem_if.sv ----
// Interface between the decoder and its general-purpose RAM.
`timescale 1ns/1ns
interface asd_mem_if #(
  parameter int AW = 10,
  parameter int DW = 8
);
  logic en;
  logic we;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;

  modport ctrl (output en, output we, output addr, output wdata, input rdata);
  modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface : asd_mem_if

// ---- include/asd_pkg.sv ----
// Constants and types shared by the address space decoder and its bench.
package asd_pkg;

  // ==========================================================================
  // Register file map.
  localparam int RF_AW = 12;
  localparam logic [11:0] RAM_FIRST = 12'h000;
  localparam logic [11:0] RAM_LAST = 12'h3ff;
  localparam logic [11:0] CTRL_FIRST = 12'hf00;
  localparam logic [11:0] TMR0_FIRST = 12'hf00;
  localparam logic [11:0] TMR0_LAST = 12'hf07;
  localparam logic [11:0] TMR1_FIRST = 12'hf08;
  localparam logic [11:0] TMR1_LAST = 12'hf0f;
  localparam logic [11:0] SER_FIRST = 12'hf40;
  localparam logic [11:0] SER_LAST = 12'hf46;
  localparam logic [11:0] SER_DATA = 12'hf40;
  localparam logic [11:0] OTHER_FIRST = 12'hf47;
  localparam logic [11:0] PGSEL_ADDR = 12'hff9;
  localparam int PGSEL_INFO_BIT = 7;
  localparam logic [7:0] PGSEL_RESET = 8'h00;
  localparam logic [7:0] UNDEF_RDATA = 8'h00;

  // ==========================================================================
  // Program memory map.
  localparam int PM_AW = 16;
  localparam logic [15:0] OPT_FIRST = 16'h0000;
  localparam logic [15:0] RST_VEC = 16'h0002;
  localparam logic [15:0] WDT_VEC = 16'h0004;
  localparam logic [15:0] TRAP_VEC = 16'h0006;
  localparam logic [15:0] IRQ_VEC_FIRST = 16'h0008;
  localparam logic [15:0] IRQ_VEC_LAST = 16'h0037;
  localparam logic [15:0] CODE_FIRST = 16'h0038;
  localparam logic [15:0] FLASH_LAST_8K = 16'h1fff;
  localparam logic [15:0] FLASH_LAST_4K = 16'h0fff;
  localparam logic [15:0] INFO_FIRST = 16'hfe00;
  localparam logic [15:0] PARTID_FIRST = 16'hfe40;
  localparam logic [15:0] PARTID_LAST = 16'hfe53;
  localparam int PARTID_LEN = 20;
  localparam logic [7:0] PM_UNIMPL_RDATA = 8'hff;

  // Program memory region of the last access, one-hot.
  typedef enum logic [7:0] {
    PMR_OPT = 8'h01,
    PMR_RSTV = 8'h02,
    PMR_WDTV = 8'h04,
    PMR_TRAPV = 8'h08,
    PMR_IRQV = 8'h10,
    PMR_CODE = 8'h20,
    PMR_INFO = 8'h40,
    PMR_NONE = 8'h80
  } asd_pmr_t;

  // Source of a register file read answer, one-hot.
  typedef enum logic [3:0] {
    RFC_RAM = 4'h1,
    RFC_PER = 4'h2,
    RFC_PGS = 4'h4,
    RFC_UND = 4'h8
  } asd_rfc_t;

  // Peripheral select lines.
  localparam int PER_TMR0 = 0;
  localparam int PER_TMR1 = 1;
  localparam int PER_SER = 2;
  localparam int PER_OTHER = 3;
  localparam int PER_N = 4;

endpackage : asd_pkg

// ---- src/asd_decoder.sv ----
// Address space decoder for register file, program memory and data memory.
`timescale 1ns/1ns
module asd_decoder #(
  parameter bit FLASH_8K = 1'b1,
  parameter bit HAS_TMR0 = 1'b1,
  parameter bit HAS_TMR1 = 1'b1,
  parameter bit HAS_SER = 1'b1,
  parameter int RAM_AW = 10,
  // Part identifier, first character in the top byte; value is arbitrary.
  parameter logic [8*asd_pkg::PARTID_LEN-1:0] PART_ID = {"ASD-DEMO-0", 80'h0}
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Register file access from the core.
  input wire logic rf_req_i,
  input wire logic rf_we_i,
  input wire logic [asd_pkg::RF_AW-1:0] rf_addr_i,
  input wire logic [7:0] rf_wdata_i,
  output logic [7:0] rf_rdata_o,
  output logic rf_rvalid_o,
  // Peripheral register port.
  output logic [asd_pkg::PER_N-1:0] per_sel_o,
  output logic per_we_o,
  output logic per_re_o,
  output logic [7:0] per_addr_o,
  output logic [7:0] per_wdata_o,
  output logic ser_tx_wr_o,
  output logic ser_rx_rd_o,
  input wire logic [7:0] per_rdata_i,
  // Program memory access from the core.
  input wire logic pm_req_i,
  input wire logic pm_we_i,
  input wire logic [asd_pkg::PM_AW-1:0] pm_addr_i,
  input wire logic [7:0] pm_wdata_i,
  output logic [7:0] pm_rdata_o,
  output logic pm_rvalid_o,
  output asd_pkg::asd_pmr_t pm_region_o,
  output logic info_en_o,
  // Flash array port.
  output logic fl_req_o,
  output logic fl_we_o,
  output logic [asd_pkg::PM_AW-1:0] fl_addr_o,
  output logic [7:0] fl_wdata_o,
  input wire logic [7:0] fl_rdata_i,
  // Data memory access from the core.
  input wire logic dm_req_i,
  input wire logic dm_we_i,
  output logic [7:0] dm_rdata_o,
  output logic dm_rvalid_o
);
  import asd_pkg::*;

  // The register file path runs in three stages: decode in the request cycle,
  // peripheral strobes from flip-flops in the next, and the answer after that.
  // Keeping the strobes registered costs a cycle of read latency but keeps the
  // long address compare away from every peripheral's write enable.
  // The program memory path answers one cycle after its request, because the
  // flash array itself needs that cycle; the overlay adds no further delay.
  // Data memory has nothing behind it and only echoes a valid pulse.

  // ==========================================================================
  // Address classification helpers.

  // Inclusive range test on register file addresses.
  function automatic logic rf_in(input logic [11:0] a, input logic [11:0] lo,
                                 input logic [11:0] hi);
    rf_in = (a >= lo) && (a <= hi);
  endfunction : rf_in

  // Inclusive range test on program memory addresses.
  function automatic logic pm_in(input logic [15:0] a, input logic [15:0] lo,
                                 input logic [15:0] hi);
    pm_in = (a >= lo) && (a <= hi);
  endfunction : pm_in

  // Part identifier byte for an overlay address; everything else reads zero.
  function automatic logic [7:0] info_byte(input logic [15:0] a);
    logic [15:0] idx;
    idx = a - PARTID_FIRST;
    info_byte = 8'h00;
    if (pm_in(a, PARTID_FIRST, PARTID_LAST)) begin
      info_byte = PART_ID[8*(PARTID_LEN-1-int'(idx[4:0])) +: 8];
    end
  endfunction : info_byte

  // The flash limit is fixed per variant, so a smaller part simply answers FF
  // above its last byte without any runtime configuration.
  localparam logic [15:0] FLASH_LAST = FLASH_8K ? FLASH_LAST_8K : FLASH_LAST_4K;
  localparam logic [11:0] RAM_TOP = RAM_FIRST + 12'((2**RAM_AW) - 1);

  // ==========================================================================
  // Register file decode, stage 0.

  asd_mem_if #(.AW(RAM_AW), .DW(8)) ram_bus ();

  // One hit flag per answering region of the register file.
  logic rf_ram_hit;
  logic rf_ctrl_hit;
  logic rf_pgs_hit;
  logic rf_tmr0_hit;
  logic rf_tmr1_hit;
  logic rf_ser_hit;
  logic rf_other_hit;

  // The whole 12-bit space is decoded; only RAM and control sections answer.
  always_comb begin
    rf_ram_hit = rf_in(rf_addr_i, RAM_FIRST, RAM_TOP) && (RAM_TOP <= RAM_LAST);
    rf_ctrl_hit = rf_addr_i >= CTRL_FIRST;
    rf_pgs_hit = rf_addr_i == PGSEL_ADDR;
    rf_tmr0_hit = HAS_TMR0 && rf_in(rf_addr_i, TMR0_FIRST, TMR0_LAST);
    rf_tmr1_hit = HAS_TMR1 && rf_in(rf_addr_i, TMR1_FIRST, TMR1_LAST);
    rf_ser_hit = HAS_SER && rf_in(rf_addr_i, SER_FIRST, SER_LAST);
    rf_other_hit = rf_ctrl_hit && (rf_addr_i >= OTHER_FIRST) && !rf_pgs_hit;
  end

  // RAM is accessed directly in the request cycle; reads take one cycle.
  always_comb begin
    ram_bus.en = rf_req_i && rf_ram_hit;
    ram_bus.we = rf_we_i;
    ram_bus.addr = rf_addr_i[RAM_AW-1:0];
    ram_bus.wdata = rf_wdata_i;
  end

  // The RAM is a separate module so that a technology macro can replace it.
  asd_ram #(.AW(RAM_AW), .DW(8)) u_ram (
    .ref_clk_i(ref_clk_i),
    .m(ram_bus)
  );

  // ==========================================================================
  // Register file stage 1: peripheral strobes and answer source.

  // Registered copies of the request, one cycle behind the core.
  logic rf_rd_q;
  logic rf_wr_q;
  logic [7:0] rf_addr_lo_q;
  logic [7:0] rf_wdata_q;
  logic [PER_N-1:0] per_sel_q;
  logic per_ser_data_q;
  logic rf_pgs_q;
  asd_rfc_t rf_cls_q;
  asd_rfc_t rf_cls_d;

  // Answer source; reserved and unimplemented locations fall to undefined.
  always_comb begin
    if (rf_ram_hit) begin
      rf_cls_d = RFC_RAM;
    end else if (rf_pgs_hit) begin
      rf_cls_d = RFC_PGS;
    end else if (rf_tmr0_hit || rf_tmr1_hit || rf_ser_hit || rf_other_hit) begin
      rf_cls_d = RFC_PER;
    end else begin
      rf_cls_d = RFC_UND;
    end
  end

  // Requests are captured so that peripheral strobes come from flip-flops.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rf_rd_q <= 1'b0;
      rf_wr_q <= 1'b0;
      rf_addr_lo_q <= 8'h00;
      rf_wdata_q <= 8'h00;
      per_sel_q <= '0;
      per_ser_data_q <= 1'b0;
      rf_pgs_q <= 1'b0;
      rf_cls_q <= RFC_UND;
    end else begin
      rf_rd_q <= rf_req_i && !rf_we_i;
      rf_wr_q <= rf_req_i && rf_we_i;
      rf_addr_lo_q <= rf_addr_i[7:0];
      rf_wdata_q <= rf_wdata_i;
      per_sel_q <= {rf_other_hit, rf_ser_hit, rf_tmr1_hit, rf_tmr0_hit} & {PER_N{rf_req_i}};
      per_ser_data_q <= rf_ser_hit && (rf_addr_i == SER_DATA);
      rf_pgs_q <= rf_req_i && rf_pgs_hit;
      rf_cls_q <= rf_cls_d;
    end
  end

  // Reserved locations get no strobe at all, so writes there change nothing.
  always_comb begin
    per_sel_o = per_sel_q;
    per_we_o = rf_wr_q && (per_sel_q != '0);
    per_re_o = rf_rd_q && (per_sel_q != '0);
    per_addr_o = rf_addr_lo_q;
    per_wdata_o = rf_wdata_q;
    ser_tx_wr_o = rf_wr_q && per_ser_data_q;
    ser_rx_rd_o = rf_rd_q && per_ser_data_q;
  end

  // ==========================================================================
  // Page select register; bit 7 opens the information area.

  logic [7:0] pgsel_q;

  // Written from the registered request, so the new enable shows two cycles
  // after the write; a read issued right behind the write gets its data under the
  // new overlay state, though its region report still follows the old one.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pgsel_q <= PGSEL_RESET;
    end else if (rf_wr_q && rf_pgs_q) begin
      pgsel_q <= rf_wdata_q;
    end
  end

  // Only bit 7 has a meaning here; the other bits are kept for read-back.
  logic info_en;
  assign info_en = pgsel_q[PGSEL_INFO_BIT];
  assign info_en_o = info_en;

  // ==========================================================================
  // Register file stage 2: read answer.

  logic [7:0] rf_rdata_q;
  logic rf_rvalid_q;

  // Peripherals answer in the cycle their strobe is high.
  // Reads of reserved space still pulse the valid flag, so the core never waits.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rf_rdata_q <= 8'h00;
      rf_rvalid_q <= 1'b0;
    end else begin
      rf_rvalid_q <= rf_rd_q;
      if (rf_rd_q) begin
        case (rf_cls_q)
          RFC_RAM: rf_rdata_q <= ram_bus.rdata;
          RFC_PER: rf_rdata_q <= per_rdata_i;
          RFC_PGS: rf_rdata_q <= pgsel_q;
          RFC_UND: rf_rdata_q <= UNDEF_RDATA;
          default: rf_rdata_q <= UNDEF_RDATA;
        endcase
      end
    end
  end

  // The read data holds until the next read answer replaces it.
  assign rf_rdata_o = rf_rdata_q;
  assign rf_rvalid_o = rf_rvalid_q;

  // ==========================================================================
  // Program memory decode, stage 0.

  // Hit flags for the flash array and the information area overlay.
  logic pm_flash_hit;
  logic pm_info_hit;

  // The overlay only covers reads; writes into it are dropped below.
  always_comb begin
    pm_flash_hit = pm_addr_i <= FLASH_LAST;
    pm_info_hit = info_en && (pm_addr_i >= INFO_FIRST);
  end

  // Flash sees only implemented addresses; nothing else is ever written.
  always_comb begin
    fl_req_o = pm_req_i && pm_flash_hit && !pm_info_hit;
    fl_we_o = pm_req_i && pm_we_i && pm_flash_hit && !pm_info_hit;
    fl_addr_o = pm_addr_i;
    fl_wdata_o = pm_wdata_i;
  end

  // Region of the access within the low vector area and beyond.
  asd_pmr_t pm_region_d;

  always_comb begin
    if (pm_info_hit) begin
      pm_region_d = PMR_INFO;
    end else if (!pm_flash_hit) begin
      pm_region_d = PMR_NONE;
    end else if (pm_addr_i < RST_VEC) begin
      pm_region_d = PMR_OPT;
    end else if (pm_addr_i < WDT_VEC) begin
      pm_region_d = PMR_RSTV;
    end else if (pm_addr_i < TRAP_VEC) begin
      pm_region_d = PMR_WDTV;
    end else if (pm_in(pm_addr_i, TRAP_VEC, IRQ_VEC_FIRST - 16'h0001)) begin
      pm_region_d = PMR_TRAPV;
    end else if (pm_in(pm_addr_i, IRQ_VEC_FIRST, IRQ_VEC_LAST)) begin
      pm_region_d = PMR_IRQV;
    end else begin
      pm_region_d = PMR_CODE;
    end
  end

  // ==========================================================================
  // Program memory stage 1: answer.

  logic pm_rd_q;
  logic [15:0] pm_addr_q;
  asd_pmr_t pm_region_q;

  // Address and region are kept from the last request so the answer mux and
  // the region report refer to the same access even after the request drops.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pm_rd_q <= 1'b0;
      pm_addr_q <= OPT_FIRST;
      pm_region_q <= PMR_NONE;
    end else begin
      pm_rd_q <= pm_req_i && !pm_we_i;
      if (pm_req_i) begin
        pm_addr_q <= pm_addr_i;
        pm_region_q <= pm_region_d;
      end
    end
  end

  // The choice follows the live enable, trading a mux in the read path
  // for overlay changes that take effect on the very next read.
  always_comb begin
    if (info_en && (pm_addr_q >= INFO_FIRST)) begin
      pm_rdata_o = info_byte(pm_addr_q);
    end else if (pm_addr_q <= FLASH_LAST) begin
      pm_rdata_o = fl_rdata_i;
    end else begin
      pm_rdata_o = PM_UNIMPL_RDATA;
    end
  end

  // Writes produce no valid pulse; only reads are answered.
  assign pm_rvalid_o = pm_rd_q;
  assign pm_region_o = pm_region_q;

  // ==========================================================================
  // Data memory: nothing is implemented, reads answer undefined.

  logic dm_rd_q;

  // A read still gets its valid pulse so a stray data memory access cannot
  // stall the core; the data is the fixed undefined value.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dm_rd_q <= 1'b0;
    end else begin
      dm_rd_q <= dm_req_i && !dm_we_i;
    end
  end

  assign dm_rvalid_o = dm_rd_q;
  assign dm_rdata_o = UNDEF_RDATA;

endmodule : asd_decoder

// ---- src/asd_ram.sv ----
// Single-port general-purpose RAM with registered read data.
`timescale 1ns/1ns
module asd_ram #(
  parameter int AW = 10,
  parameter int DW = 8
) (
  // Clock.
  input wire logic ref_clk_i,
  // Access port.
  asd_mem_if.mem m
);

  logic [DW-1:0] mem_q [2**AW];

  // RAM content has no reset, so power-up content is undefined as for real RAM.
  always_ff @(posedge ref_clk_i) begin
    if (m.en && m.we) begin
      mem_q[m.addr] <= m.wdata;
    end
  end

  // Read data comes from a register, one cycle after the enable.
  always_ff @(posedge ref_clk_i) begin
    if (m.en && !m.we) begin
      m.rdata <= mem_q[m.addr];
    end
  end

endmodule : asd_ram
